// ---- cbt_core.v ----
// CAN bit timing logic, bit stream state machine and AXI4-Lite register slave
`timescale 1ns/1ps
`include "cbt_regs.vh"
module cbt_core #(
  parameter ADDR_W = 8
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire              can_rx,
  output reg               can_tx
);

  localparam T_SYNC = 2'd0;
  localparam T_SEG1 = 2'd1;
  localparam T_SEG2 = 2'd2;

  localparam B_IDLE  = 3'd0;
  localparam B_FRAME = 3'd1;
  localparam B_TAIL  = 3'd2;
  localparam B_ERRF  = 3'd3;
  localparam B_WAIT  = 3'd4;

  ////////////////////////////////////////////////////////////////////////
  // Functions
  function [14:0] crc_step;
    input [14:0] c;
    input        b;
    begin
      crc_step = {c[13:0], 1'b0} ^ ((b ^ c[14]) ? `CBT_CRC_POLY : 15'h0000);
    end
  endfunction

  // Bit that goes out at a given frame position
  function next_bit;
    input [5:0]  pos;
    input [31:0] sh;
    input [14:0] crc;
    begin
      if (pos == 6'd0)
        next_bit = 1'b0;
      else if (pos <= `CBT_POS_DATA_LAST)
        next_bit = sh[31];
      else if (pos <= `CBT_POS_CRC_LAST)
        next_bit = crc[14];
      else
        next_bit = 1'b1;
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i])
          merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  function is_at;
    input [ADDR_W-1:0] a;
    input [7:0]        off;
    begin
      is_at = ({a[ADDR_W-1:2], 2'b00} == off);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State
  reg              init_r;
  reg              tx_pend_r;
  reg [14:0]       btime_r;
  reg [31:0]       txd_r;
  reg [31:0]       rxd_r;
  reg [5:0]        flags_r;
  reg              aw_got_r;
  reg              w_got_r;
  reg [ADDR_W-1:0] awaddr_r;
  reg [31:0]       wdata_r;
  reg [3:0]        wstrb_r;
  reg [2:0]        rx_s_r;
  reg              bus_lvl_r;
  reg [1:0]        bt_st_r;
  reg [4:0]        tq_cnt_r;
  reg [4:0]        ext_r;
  reg [4:0]        short_r;
  reg              synced_r;
  reg              sampled_r;
  reg [2:0]        bs_st_r;
  reg [5:0]        pos_r;
  reg [2:0]        run_r;
  reg              last_r;
  reg [14:0]       crc_r;
  reg [31:0]       sh_r;
  reg              txing_r;
  reg [3:0]        cnt_r;
  wire             tq_p;

  // Field decode, stored-minus-one offset removed from jump and segment lengths
  wire [5:0] psc_w   = btime_r[`CBT_PSC_MSB:`CBT_PSC_LSB];
  wire [4:0] jmp_f   = {3'b000, btime_r[`CBT_JMP_MSB:`CBT_JMP_LSB]} + 5'd1;
  wire [4:0] bef_f   = {1'b0, btime_r[`CBT_BEF_MSB:`CBT_BEF_LSB]} + 5'd1;
  wire [4:0] aft_f   = {2'b00, btime_r[`CBT_AFT_MSB:`CBT_AFT_LSB]} + 5'd1;

  cbt_prescaler #(
    .CNT_W (6)
  ) u_presc (
    .aclk              (aclk),
    .aresetn           (aresetn),
    .enable            (~init_r),
    .quantum_prescaler (psc_w),
    .tq_p              (tq_p)
  );

  ////////////////////////////////////////////////////////////////////////
  // Bus input: three flops, level accepted once second and third agree
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_s_r    <= 3'h7;
      bus_lvl_r <= 1'b1;
    end else begin
      rx_s_r <= {rx_s_r[1:0], can_rx};
      if (rx_s_r[1] == rx_s_r[2])
        bus_lvl_r <= rx_s_r[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bit timing logic, one step per quantum
  wire       hard_w   = (bs_st_r == B_IDLE);
  wire       edge_w   = tq_p & ~bus_lvl_r & sampled_r & ~synced_r;
  wire [4:0] late_e   = tq_cnt_r + 5'd1;
  wire [4:0] late_x   = (late_e < jmp_f) ? late_e : jmp_f;
  wire [4:0] ext_now  = (edge_w && !hard_w) ? late_x : ext_r;
  wire [4:0] early_e  = aft_f - tq_cnt_r;
  wire [4:0] short_nw = edge_w ? jmp_f : short_r;
  wire       seg1_end = ((tq_cnt_r + 5'd1) >= (bef_f + ext_now));
  wire       seg2_end = ((tq_cnt_r + 5'd1) >= (aft_f - short_nw));
  wire       sample_w = tq_p && (bt_st_r == T_SEG1) && seg1_end
                        && !(edge_w && hard_w);
  wire       s        = bus_lvl_r;

  always @(posedge aclk) begin
    if (!aresetn || init_r) begin
      bt_st_r   <= T_SYNC;
      tq_cnt_r  <= 5'd0;
      ext_r     <= 5'd0;
      short_r   <= 5'd0;
      synced_r  <= 1'b0;
      sampled_r <= 1'b1;
    end else if (tq_p) begin
      case (bt_st_r)
        T_SYNC: begin
          synced_r <= synced_r | edge_w; // Edge inside sync is already aligned
          bt_st_r  <= T_SEG1;
          tq_cnt_r <= 5'd0;
        end
        T_SEG1: begin
          if (edge_w && hard_w) begin
            synced_r <= 1'b1;
            ext_r    <= 5'd0;
            tq_cnt_r <= 5'd0;
          end else if (seg1_end) begin
            sampled_r <= s;
            synced_r  <= 1'b0;
            ext_r     <= 5'd0;
            bt_st_r   <= T_SEG2;
            tq_cnt_r  <= 5'd0;
          end else begin
            if (edge_w)
              synced_r <= 1'b1;
            ext_r    <= ext_now;
            tq_cnt_r <= tq_cnt_r + 5'd1;
          end
        end
        T_SEG2: begin
          // Early edge within jump width: this quantum becomes the sync slot
          if (edge_w && (hard_w || early_e <= jmp_f)) begin
            synced_r <= 1'b1;
            short_r  <= 5'd0;
            bt_st_r  <= T_SEG1;
            tq_cnt_r <= 5'd0;
          end else if (seg2_end) begin
            synced_r <= synced_r | edge_w;
            short_r  <= 5'd0;
            bt_st_r  <= T_SYNC;
            tq_cnt_r <= 5'd0;
          end else begin
            synced_r <= synced_r | edge_w;
            short_r  <= short_nw;
            tq_cnt_r <= tq_cnt_r + 5'd1;
          end
        end
        default: begin
          bt_st_r  <= T_SYNC;
          tq_cnt_r <= 5'd0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bit stream next values and error detection
  wire        stuff_w = (run_r == `CBT_STUFF_RUN);
  wire [2:0]  run_n   = (s == last_r) ? run_r + 3'd1 : 3'd1;
  wire        in_crc  = (pos_r > `CBT_POS_DATA_LAST) && (pos_r <= `CBT_POS_CRC_LAST);
  wire        in_data = (pos_r != 6'd0) && (pos_r <= `CBT_POS_DATA_LAST);
  wire [14:0] crc_n   = in_crc ? {crc_r[13:0], 1'b0} : crc_step(crc_r, s);
  wire [31:0] sh_n    = in_data ? {sh_r[30:0], s} : sh_r;
  wire [5:0]  pos_n   = pos_r + 6'd1;
  wire        in_frm  = sample_w && (bs_st_r == B_FRAME);
  wire        bit_err = sample_w && txing_r && (s != can_tx)
                        && (bs_st_r == B_FRAME || bs_st_r == B_TAIL);
  wire        stf_err = in_frm && stuff_w && (s == last_r);
  wire        crc_err = in_frm && !stuff_w && in_crc && (s != crc_r[14]);
  wire        frm_err = sample_w && (bs_st_r == B_TAIL) && !s;
  wire        any_err = bit_err | stf_err | crc_err | frm_err;
  wire        done_w  = sample_w && (bs_st_r == B_TAIL)
                        && (cnt_r == `CBT_TAIL_LAST) && !any_err;
  wire [5:0]  ev_w    = {frm_err, crc_err, stf_err, bit_err,
                         done_w & ~txing_r, done_w & txing_r};
  wire        start_w = sample_w && (bs_st_r == B_IDLE) && s && tx_pend_r;

  ////////////////////////////////////////////////////////////////////////
  // Bit stream state machine, one step per sample point
  always @(posedge aclk) begin
    if (!aresetn || init_r) begin
      bs_st_r <= B_IDLE;
      pos_r   <= 6'd0;
      run_r   <= 3'd0;
      last_r  <= 1'b1;
      crc_r   <= 15'h0000;
      sh_r    <= 32'h0000_0000;
      txing_r <= 1'b0;
      cnt_r   <= 4'd0;
      can_tx  <= 1'b1;
      rxd_r   <= rxd_r & {32{aresetn}};
    end else if (sample_w) begin
      if (any_err) begin
        bs_st_r <= B_ERRF;
        cnt_r   <= 4'd0;
        can_tx  <= 1'b0;
      end else begin
        case (bs_st_r)
          B_IDLE: begin
            pos_r  <= 6'd1;
            run_r  <= 3'd1;
            last_r <= 1'b0;
            crc_r  <= 15'h0000;
            if (!s) begin
              bs_st_r <= B_FRAME;
              txing_r <= 1'b0;
            end else if (tx_pend_r) begin
              bs_st_r <= B_FRAME;
              txing_r <= 1'b1;
              pos_r   <= 6'd0;
              run_r   <= 3'd0;
              last_r  <= 1'b1;
              sh_r    <= txd_r;
              can_tx  <= 1'b0;
            end
          end
          B_FRAME: begin
            last_r <= s;
            if (stuff_w) begin
              run_r <= 3'd1;
              if (pos_r == `CBT_POS_END) begin
                bs_st_r <= B_TAIL;
                cnt_r   <= 4'd0;
                can_tx  <= 1'b1;
              end else begin
                can_tx <= txing_r ? next_bit(pos_r, sh_r, crc_r) : 1'b1;
              end
            end else begin
              pos_r <= pos_n;
              run_r <= run_n;
              crc_r <= crc_n;
              sh_r  <= sh_n;
              if (pos_n == `CBT_POS_END && run_n != `CBT_STUFF_RUN) begin
                bs_st_r <= B_TAIL;
                cnt_r   <= 4'd0;
                can_tx  <= 1'b1;
              end else if (txing_r) begin
                can_tx <= (run_n == `CBT_STUFF_RUN) ? ~s : next_bit(pos_n, sh_n, crc_n);
              end else begin
                can_tx <= 1'b1;
              end
            end
          end
          B_TAIL: begin
            cnt_r <= cnt_r + 4'd1;
            if (cnt_r == `CBT_TAIL_LAST) begin
              if (!txing_r)
                rxd_r <= sh_r;
              txing_r <= 1'b0;
              bs_st_r <= B_IDLE;
            end
          end
          B_ERRF: begin
            cnt_r <= cnt_r + 4'd1;
            if (cnt_r == `CBT_ERRF_LAST) begin
              can_tx  <= 1'b1;
              cnt_r   <= 4'd0;
              bs_st_r <= B_WAIT;
            end
          end
          B_WAIT: begin
            txing_r <= 1'b0;
            if (!s)
              cnt_r <= 4'd0;
            else if (cnt_r == `CBT_IDLE_LAST)
              bs_st_r <= B_IDLE;
            else
              cnt_r <= cnt_r + 4'd1;
          end
          default: begin
            bs_st_r <= B_IDLE;
            can_tx  <= 1'b1;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path: address and data taken in either order
  wire wr_do = aw_got_r && w_got_r && !s_axi_bvalid;
  // Timing word keeps only its low 15 bits
  wire [31:0] btime_m = merge({17'h0, btime_r}, wdata_r, wstrb_r);
  wire [31:0] st_word = {21'h0, tx_pend_r, s, (bs_st_r != B_IDLE), 2'b00, flags_r};

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CBT_RESP_OKAY;
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      awaddr_r      <= {ADDR_W{1'b0}};
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      init_r        <= `CBT_CTRL_RST;
      tx_pend_r     <= 1'b0;
      btime_r       <= `CBT_BTIME_RST;
      txd_r         <= 32'h0000_0000;
      flags_r       <= 6'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_got_r      <= 1'b1;
        awaddr_r      <= s_axi_awaddr;
      end else if (!aw_got_r && !s_axi_bvalid)
        s_axi_awready <= 1'b1;
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_got_r      <= 1'b1;
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
      end else if (!w_got_r && !s_axi_bvalid)
        s_axi_wready <= 1'b1;
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      // Event sets win over a same-cycle software clear
      flags_r <= flags_r | ev_w;
      if (start_w)
        tx_pend_r <= 1'b0;
      if (wr_do) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `CBT_RESP_OKAY;
        if (is_at(awaddr_r, `CBT_OFF_CTRL)) begin
          if (wstrb_r[0]) begin
            init_r <= wdata_r[`CBT_CTRL_INIT];
            if (wdata_r[`CBT_CTRL_TXREQ])
              tx_pend_r <= 1'b1;
          end
        end else if (is_at(awaddr_r, `CBT_OFF_STATUS)) begin
          if (wstrb_r[0])
            flags_r <= (flags_r & ~wdata_r[5:0]) | ev_w;
        end else if (is_at(awaddr_r, `CBT_OFF_BTIME)) begin
          // Retiming a bit in flight would corrupt the frame
          if (init_r)
            btime_r <= btime_m[14:0];
        end else if (is_at(awaddr_r, `CBT_OFF_TXDATA)) begin
          txd_r <= merge(txd_r, wdata_r, wstrb_r);
        end else if (!is_at(awaddr_r, `CBT_OFF_RXDATA)) begin
          s_axi_bresp <= `CBT_RESP_SLVERR;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `CBT_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `CBT_RESP_OKAY;
        if (is_at(s_axi_araddr, `CBT_OFF_CTRL))
          s_axi_rdata <= {30'h0, tx_pend_r, init_r};
        else if (is_at(s_axi_araddr, `CBT_OFF_STATUS))
          s_axi_rdata <= st_word;
        else if (is_at(s_axi_araddr, `CBT_OFF_BTIME))
          s_axi_rdata <= {17'h0, btime_r};
        else if (is_at(s_axi_araddr, `CBT_OFF_TXDATA))
          s_axi_rdata <= txd_r;
        else if (is_at(s_axi_araddr, `CBT_OFF_RXDATA))
          s_axi_rdata <= rxd_r;
        else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `CBT_RESP_SLVERR;
        end
      end else if (!s_axi_rvalid)
        s_axi_arready <= 1'b1;
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ---- cbt_regs.vh ----
// Register offsets, field positions, reset values and frame counts for the bit timing core
`ifndef CBT_REGS_VH
`define CBT_REGS_VH

`define CBT_OFF_CTRL      8'h00
`define CBT_OFF_STATUS    8'h04
`define CBT_OFF_BTIME     8'h0c
`define CBT_OFF_TXDATA    8'h10
`define CBT_OFF_RXDATA    8'h14

`define CBT_CTRL_INIT     0
`define CBT_CTRL_TXREQ    1
`define CBT_CTRL_RST      1'h1

`define CBT_BTIME_RST     15'h2301
`define CBT_PSC_LSB       0
`define CBT_PSC_MSB       5
`define CBT_JMP_LSB       6
`define CBT_JMP_MSB       7
`define CBT_BEF_LSB       8
`define CBT_BEF_MSB       11
`define CBT_AFT_LSB       12
`define CBT_AFT_MSB       14

`define CBT_ST_BUSY       8
`define CBT_ST_BUS        9
`define CBT_ST_PEND       10

`define CBT_CRC_POLY      15'h4599
`define CBT_POS_DATA_LAST 6'd32
`define CBT_POS_CRC_LAST  6'd47
`define CBT_POS_END       6'd48
`define CBT_STUFF_RUN     3'd5
`define CBT_TAIL_LAST     4'd7
`define CBT_ERRF_LAST     4'd5
`define CBT_IDLE_LAST     4'd6

`define CBT_RESP_OKAY     2'h0
`define CBT_RESP_SLVERR   2'h2

`endif

// ---- cbt_prescaler.v ----
// Time quantum prescaler: one-cycle enable every quantum_prescaler+1 clocks
`timescale 1ns/1ps
module cbt_prescaler #(
  parameter CNT_W = 6
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire             enable,
  input  wire [CNT_W-1:0] quantum_prescaler,
  output reg              tq_p
);

  reg [CNT_W-1:0] cnt_r;

  ////////////////////////////////////////////////////////////////////////
  // Stored value plus one clocks per quantum; held cleared while disabled
  always @(posedge aclk) begin
    if (!aresetn || !enable) begin
      cnt_r <= {CNT_W{1'b0}};
      tq_p  <= 1'b0;
    end else if (cnt_r == quantum_prescaler) begin
      cnt_r <= {CNT_W{1'b0}};
      tq_p  <= 1'b1;
    end else begin
      cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
      tq_p  <= 1'b0;
    end
  end

endmodule

// ---- cbt_core_asserts.sv ----
// Port-level checks for the bit timing core: bus handshakes and line idling
`timescale 1ns/1ps
module cbt_core_asserts #(parameter ADDR_W = 8) (
  input wire              aclk,
  input wire              aresetn,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire              s_axi_awvalid,
  input wire              s_axi_awready,
  input wire [31:0]       s_axi_wdata,
  input wire              s_axi_wvalid,
  input wire              s_axi_wready,
  input wire [1:0]        s_axi_bresp,
  input wire              s_axi_bvalid,
  input wire              s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire              s_axi_arvalid,
  input wire              s_axi_arready,
  input wire [31:0]       s_axi_rdata,
  input wire [1:0]        s_axi_rresp,
  input wire              s_axi_rvalid,
  input wire              s_axi_rready,
  input wire              can_tx
);
  logic [ADDR_W-1:0] wa_r;
  logic [ADDR_W-1:0] ra_r;
  logic [31:0]       wd_r;
  logic              init_r;
  wire               hit = ra_r[ADDR_W-1:2] inside {0, 1, 3, 4, 5};
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  //////////////////////////////////////////////////
  // Shadow of targets; init lags the core by one cycle, safe for idle check
  always @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) wa_r <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) wd_r <= s_axi_wdata;
    if (s_axi_arvalid && s_axi_arready) ra_r <= s_axi_araddr;
    if (!aresetn) init_r <= 1'h1;
    else if ($rose(s_axi_bvalid) && wa_r[ADDR_W-1:2] == 0) init_r <= wd_r[0];
  end
  // Handshake steps
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  //////////////////////////////////////////////////
  a_b_timing: assert property (s_wr_take |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_ready_drop: assert property (s_wr_take |=> !s_axi_awready && !s_axi_wready)
    else $error("write ready not dropped");
  a_r_timing: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read answer late");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  a_unmapped_err: assert property (s_axi_rvalid && !hit |->
    s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read");
  a_mapped_ok: assert property (s_axi_rvalid && hit |-> s_axi_rresp == 2'h0)
    else $error("mapped read refused");
  a_btime_width: assert property (
    s_axi_rvalid && ra_r[ADDR_W-1:2] == 3 |-> s_axi_rdata[31:15] == 17'h0)
    else $error("timing word too wide");
  a_idle_init: assert property (init_r && $past(init_r) |-> can_tx)
    else $error("line driven in init");
endmodule
bind cbt_core cbt_core_asserts #(.ADDR_W(ADDR_W)) u_chk (.*);

// ---- cbt_bus_node.sv ----
// Remote bus node: wired-AND line with pull-up and a bit-serial sender
`timescale 1ns/1ps
module cbt_bus_node (
  input  wire  aclk,
  input  wire  dut_tx,
  output logic bus
);
  logic node_tx = 1'h1;
  // Dominant from either node wins; a released line is recessive
  assign bus = dut_tx & node_tx;
  // One bit per period, index 0 first, changed just after an edge
  task send(input logic [127:0] f, input int n, input int per);
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      node_tx <= f[i];
      repeat (per - 1) @(posedge aclk);
    end
    @(posedge aclk);
    node_tx <= 1'h1;
  endtask
  // Hold the line dominant, as a colliding node would
  task pull(input int d);
    @(posedge aclk);
    node_tx <= 1'h0;
    repeat (d) @(posedge aclk);
    node_tx <= 1'h1;
  endtask
endmodule

// ---- test_cbt_core.sv ----
// Bench for the bit timing core: registers, frame out, frame in, bit error
`timescale 1ns/1ps
`include "cbt_regs.vh"
module test_cbt_core;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire can_tx, bus;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  logic [127:0] fr;
  logic [31:0] v;
  int errors = 0;
  int n_checks = 0;
  int fn;
  // 2 clocks a quantum; prop 2 + phase1 2, phase2 3, jump 2
  localparam logic [14:0] BT = 15'h2341;
  localparam int BP = (BT[5:0] + 1) * (BT[11:8] + BT[14:12] + 3);
  always #2.5 aclk = ~aclk;
  cbt_core u_dut (.*, .can_rx(bus));
  cbt_bus_node u_node (.aclk, .dut_tx(can_tx), .bus);
  //////////////////////////////////////////////////
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // Write: address and data offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    chk(s_axi_bresp, r);
    s_axi_bready <= 1'h0;
  endtask
  task rd(input logic [7:0] a, input logic [1:0] r, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    chk(s_axi_rresp, r);
    s_axi_rready <= 1'h0;
  endtask
  // Expected line bits: start, data msb first, check word, stuffing, tail
  task mk(input logic [31:0] d);
    logic [47:0] b;
    logic [14:0] c;
    logic p;
    int run;
    b = {1'h0, d, 15'h0};
    c = 15'h0;
    for (int i = 47; i > 14; i--)
      c = {c[13:0], 1'h0} ^ ((b[i] ^ c[14]) ? `CBT_CRC_POLY : 15'h0);
    b[14:0] = c;
    fn = 0;
    p = 1'h1;
    run = 0;
    for (int i = 47; i >= 0; i--) begin
      if (run == 5) begin
        p = ~p;
        fr[fn++] = p;
        run = 1;
      end
      if (b[i] == p) run++;
      else run = 1;
      p = b[i];
      fr[fn++] = p;
    end
    if (run == 5) fr[fn++] = ~p;
    repeat (8) fr[fn++] = 1'h1;
  endtask
  // Decode the core's line by run lengths; tolerant of hard sync and resync
  task txchk;
    int idx, cnt;
    logic l;
    idx = 0;
    while (can_tx !== 1'h0) @(posedge aclk);
    while (idx < fn) begin
      l = can_tx;
      cnt = 0;
      while (can_tx === l && cnt < 400) begin
        @(posedge aclk);
        cnt++;
      end
      repeat ((cnt + BP / 2) / BP) if (idx < fn) chk(l, fr[idx++]);
    end
  endtask
  task finish_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  //////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(`CBT_OFF_CTRL, 2'h0, v);
    chk(v, 32'h1);
    rd(`CBT_OFF_BTIME, 2'h0, v);
    chk(v, 32'h2301);
    rd(8'h08, `CBT_RESP_SLVERR, v);
    chk(v, 32'h0);
    wr(8'h08, 32'h1, `CBT_RESP_SLVERR);
    wr(`CBT_OFF_BTIME, {17'h1ffff, BT}, 2'h0);
    rd(`CBT_OFF_BTIME, 2'h0, v);
    chk(v, BT);
    wr(`CBT_OFF_CTRL, 32'h0, 2'h0);
    wr(`CBT_OFF_BTIME, 32'h1600, 2'h0);
    rd(`CBT_OFF_BTIME, 2'h0, v);
    chk(v, BT);
    // Byte lanes: only the strobed middle bytes may change
    wr(`CBT_OFF_TXDATA, 32'h1122_3344, 2'h0);
    s_axi_wstrb <= 4'h6;
    wr(`CBT_OFF_TXDATA, 32'haabb_ccdd, 2'h0);
    s_axi_wstrb <= 4'hf;
    rd(`CBT_OFF_TXDATA, 2'h0, v);
    chk(v, 32'h11bb_cc44);
    // Frame out, with long equal runs that force stuffing
    mk(32'hf800_07c1);
    wr(`CBT_OFF_TXDATA, 32'hf800_07c1, 2'h0);
    wr(`CBT_OFF_CTRL, 32'h2, 2'h0);
    txchk;
    rd(`CBT_OFF_STATUS, 2'h0, v);
    chk(v & 32'h3d, 32'h1);
    wr(`CBT_OFF_STATUS, 32'hff, 2'h0);
    rd(`CBT_OFF_STATUS, 2'h0, v);
    chk(v & 32'h3f, 32'h0);
    // Frame in from the remote node at an arbitrary phase
    mk(32'h1234_5678);
    u_node.send(fr, fn, BP);
    repeat (4 * BP) @(posedge aclk);
    rd(`CBT_OFF_RXDATA, 2'h0, v);
    chk(v, 32'h1234_5678);
    rd(`CBT_OFF_STATUS, 2'h0, v);
    chk(v & 32'h3e, 32'h2);
    // Collision on a recessive bit: only the bit error flag is checked
    wr(`CBT_OFF_STATUS, 32'hff, 2'h0);
    wr(`CBT_OFF_TXDATA, 32'hffff_ffff, 2'h0);
    wr(`CBT_OFF_CTRL, 32'h2, 2'h0);
    while (can_tx !== 1'h0) @(posedge aclk);
    repeat (2 * BP) @(posedge aclk);
    u_node.pull(3 * BP);
    repeat (30 * BP) @(posedge aclk);
    rd(`CBT_OFF_STATUS, 2'h0, v);
    chk(v & 32'h4, 32'h4);
    finish_test;
  end
  // Hang guard, well past the expected few thousand cycles
  initial begin
    #100000;
    errors++;
    finish_test;
  end
endmodule
